// File: src/mts_pkg.sv
package mts_pkg;
  // ==========================================================
  // Frame geometry
  localparam int NUM_LINES  = 32;
  localparam int LINE_W     = 5;
  localparam int SLOTS      = 64;
  localparam int SLOT_W     = 6;
  localparam int CH_W       = SLOT_W + LINE_W;
  localparam int CHANNELS   = SLOTS * NUM_LINES;
  localparam int BIT_W      = 3;
  localparam int DIV_W      = 2;
  localparam int FC_W       = SLOT_W + BIT_W + DIV_W;
  localparam int MEAS_W     = 12;
  localparam int NUM_SHIFT  = 16;
  localparam int SHIFT_W    = 2;
  localparam int SHIFT_DEP  = 4;
  localparam int NUM_FS     = 6;
  localparam int FS_W       = 3;
  localparam int CM_W       = 12;
  localparam int CM_TS_BIT  = 11;
  localparam int ST_CNT_W   = 16;
  localparam logic [FC_W-1:0]     FC_LAST  = 11'h7FF;
  localparam logic [BIT_W-1:0]    BIT_LAST = 3'h7;
  localparam logic [DIV_W-1:0]    DIV_LAST = 2'h3;
  localparam logic [CH_W-1:0]     CH_LAST  = 11'h7FF;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int SELFTEST_STEP_NS = 625_000;
  localparam int ST_STEP_CYC_DEF  =
    (SELFTEST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_IRQ    = 8'h03;
  localparam logic [7:0] ADDR_MEAS_L = 8'h04;
  localparam logic [7:0] ADDR_MEAS_H = 8'h05;
  localparam logic [7:0] ADDR_OSHIFT = 8'h06;
  localparam logic [7:0] ADDR_ICS0   = 8'h08;
  localparam logic [7:0] ADDR_IND_AL = 8'h10;
  localparam logic [7:0] ADDR_IND_AH = 8'h11;
  localparam logic [7:0] ADDR_IND_DL = 8'h12;
  localparam logic [7:0] ADDR_IND_DH = 8'h13;
  // Field positions
  localparam int MODE_SHIFT_SEL = 0;
  localparam int MODE_ALL32     = 1;
  localparam int MODE_EN_LO     = 2;
  localparam int MODE_EN_HI     = 3;
  localparam int CMD_MEAS       = 3;
  localparam int CMD_CMCLR      = 4;
  localparam int CMD_BIST       = 5;
  localparam int IRQ_SYNC_LOST  = 0;
  localparam int IRQ_SYNC_OK    = 1;
  localparam int IRQ_CMCLR      = 2;
  localparam int IRQ_MEAS       = 3;
  localparam int IRQ_BIST       = 4;
  localparam int IRQ_W          = 5;
  localparam int IND_SEL_DM     = 4;
  localparam int IND_SEL_B      = 5;
  localparam int IND_READ       = 7;
  // Selftest phases and patterns
  localparam logic [1:0]      PH_WRITE  = 2'h0;
  localparam logic [1:0]      PH_CHECK  = 2'h1;
  localparam logic [1:0]      PH_CLEAR  = 2'h2;
  localparam logic [7:0]      DM_PAT    = 8'hA5;
  localparam logic [CH_W-1:0] CM_PAT    = 11'h5A5;
  localparam logic [CM_W-1:0] CM_CLEAR  = 12'h800;

  typedef enum logic [1:0] {
    MTS_IDLE  = 2'b00,
    MTS_CMCLR = 2'b01,
    MTS_BIST1 = 2'b10,
    MTS_BIST2 = 2'b11
  } mts_func_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mts_bus_s;
endpackage

// File: src/mts_switch.sv
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module mts_switch
  import mts_pkg::*;
#(
  parameter int ST_STEP_CYC = ST_STEP_CYC_DEF
) (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire mts_bus_s             bus_i,
  output logic [7:0]                rdata_o,
  input  wire logic                 frame_sync_pulse_i,
  input  wire logic [NUM_LINES-1:0] serial_in_i,
  input  wire logic [NUM_FS-1:0]    frame_measure_in_i,
  input  wire logic                 bist_start_i,
  output logic [NUM_LINES-1:0]      serial_out_o,
  output logic [NUM_LINES-1:0]      serial_out_oe_o,
  output logic                      irq_n_o,
  output logic                      irq_oe_o,
  output logic                      bist_done_o,
  output logic                      bist_ok_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]                               sp_s;
    logic                                     sp_d;
    logic [NUM_LINES-1:0]                     in_s1;
    logic [NUM_LINES-1:0]                     in_s2;
    logic [NUM_FS-1:0]                        fs_s1;
    logic [NUM_FS-1:0]                        fs_s2;
    logic [NUM_FS-1:0]                        fs_d;
    logic [FC_W-1:0]                          fcnt;
    logic                                     synced;
    logic [NUM_LINES-1:0][SHIFT_DEP-1:0]      in_dly;
    logic [NUM_LINES-1:0][7:0]                in_sr;
    logic [NUM_LINES-1:0][7:0]                out_sr;
    logic [NUM_LINES-1:0]                     out_ts;
    logic [NUM_LINES-1:0][SHIFT_DEP-1:0]      out_dly;
    logic [NUM_LINES-1:0][SHIFT_DEP-1:0]      oe_dly;
    logic [NUM_LINES-1:0]                     sout;
    logic [NUM_LINES-1:0]                     soe;
    logic [7:0]                               mode;
    logic [NUM_SHIFT*SHIFT_W-1:0]             ics;
    logic [SHIFT_W-1:0]                       oshift;
    logic [IRQ_W-1:0]                         irq_stat;
    logic                                     irq_n;
    logic                                     irq_oe;
    logic                                     meas_busy;
    logic [FS_W-1:0]                          meas_idx;
    logic [MEAS_W-1:0]                        meas;
    mts_func_e                                func;
    logic [ST_CNT_W-1:0]                      st_cnt;
    logic                                     bist_fail;
    logic                                     bist_ok;
    logic                                     bist_done;
    logic [CH_W-1:0]                          ind_addr;
    logic [1:0]                               ind_sel;
    logic [CM_W-1:0]                          ind_data;
    logic                                     ind_wr;
    logic                                     ind_rd;
    logic [7:0]                               rdata;
  } mts_state_s;

  mts_state_s r_reg;
  mts_state_s r_next;

  // Select field keeps only bits 5:4 of the address-high byte
  localparam int SEL_DM = IND_SEL_DM - IND_SEL_DM;
  localparam int SEL_B  = IND_SEL_B - IND_SEL_DM;

  // Memories hold no reset; software clears the control memory.
  logic [7:0]      dm_a [CHANNELS];
  logic [7:0]      dm_b [CHANNELS];
  logic [CM_W-1:0] cm_a [CHANNELS];
  logic [CM_W-1:0] cm_b [CHANNELS];

  logic [DIV_W-1:0]                 div_pos;
  logic [BIT_W-1:0]                 bit_pos;
  logic [SLOT_W-1:0]                slot;
  logic [SLOT_W-1:0]                next_slot;
  logic                             bit_en;
  logic                             byte_end;
  logic                             sp_rise;
  logic [CH_W-1:0]                  st_addr;
  logic [1:0]                       st_phase;
  logic [NUM_LINES-1:0]             in_bit;
  logic [NUM_LINES-1:0][CM_W-1:0]   ld_ent;
  logic [NUM_LINES-1:0][7:0]        ld_byte;
  logic [CM_W-1:0]                  ind_rd_val;
  logic                             st_ok;
  logic [IRQ_W-1:0]                 ev;
  logic                             rd_clr;
  logic                             bist_go;

  function automatic logic [3:0] shift_idx(input int l, input logic all32);
    logic [LINE_W-1:0] ln;
    ln = LINE_W'(l);
    shift_idx = all32 ? ln[4:1] : ln[3:0];
  endfunction

  function automatic logic upper_line(input int l);
    upper_line = (l >= NUM_LINES / 2);
  endfunction

  // ==========================================================
  // Counters
  assign div_pos   = r_reg.fcnt[DIV_W-1:0];
  assign bit_pos   = r_reg.fcnt[DIV_W +: BIT_W];
  assign slot      = r_reg.fcnt[DIV_W+BIT_W +: SLOT_W];
  assign next_slot = slot + 1'b1;
  assign bit_en    = (div_pos == DIV_LAST);
  assign byte_end  = bit_en && (bit_pos == BIT_LAST);
  assign sp_rise   = r_reg.sp_s[1] & ~r_reg.sp_d;
  assign st_addr   = r_reg.st_cnt[CH_W-1:0];
  assign st_phase  = r_reg.st_cnt[CH_W +: 2];

  // ==========================================================
  // Memory reads
  always_comb begin
    for (int l = 0; l < NUM_LINES; l++) begin
      in_bit[l] = r_reg.in_dly[l][r_reg.ics[
        {shift_idx(l, r_reg.mode[MODE_ALL32]), 1'b0} +: SHIFT_W]];
      if (upper_line(l)) begin
        ld_ent[l]  = cm_b[{next_slot, LINE_W'(l)}];
        ld_byte[l] = dm_b[ld_ent[l][CH_W-1:0]];
      end else begin
        ld_ent[l]  = cm_a[{next_slot, LINE_W'(l)}];
        ld_byte[l] = dm_a[ld_ent[l][CH_W-1:0]];
      end
    end
    if (r_reg.ind_sel[SEL_DM]) begin
      ind_rd_val = {4'h0, r_reg.ind_sel[SEL_B] ?
                    dm_b[r_reg.ind_addr] : dm_a[r_reg.ind_addr]};
    end else begin
      ind_rd_val = r_reg.ind_sel[SEL_B] ?
                   cm_b[r_reg.ind_addr] : cm_a[r_reg.ind_addr];
    end
    if (r_reg.func == MTS_BIST1) begin
      st_ok = (dm_a[st_addr] == (st_addr[7:0] ^ DM_PAT)) &&
              (dm_b[st_addr] == (st_addr[7:0] ^ DM_PAT));
    end else begin
      st_ok = (cm_a[st_addr] == {1'b0, st_addr ^ CM_PAT}) &&
              (cm_b[st_addr] == {1'b0, st_addr ^ CM_PAT});
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    ev     = '0;
    rd_clr = 1'b0;
    bist_go = bist_start_i;
    r_next.ind_wr    = 1'b0;
    r_next.ind_rd    = 1'b0;
    r_next.bist_done = 1'b0;
    r_next.sp_s  = {r_reg.sp_s[0], frame_sync_pulse_i};
    r_next.sp_d  = r_reg.sp_s[1];
    r_next.in_s1 = serial_in_i;
    r_next.in_s2 = r_reg.in_s1;
    r_next.fs_s1 = frame_measure_in_i;
    r_next.fs_s2 = r_reg.fs_s1;
    r_next.fs_d  = r_reg.fs_s2;

    // Frame counter and length check
    r_next.fcnt = r_reg.fcnt + 1'b1;
    if (sp_rise) begin
      r_next.fcnt = '0;
      if (r_reg.fcnt == FC_LAST) begin
        r_next.synced = 1'b1;
        ev[IRQ_SYNC_OK] = ~r_reg.synced;
      end else begin
        r_next.synced = 1'b0;
        ev[IRQ_SYNC_LOST] = r_reg.synced;
      end
    end else if (r_reg.synced && r_reg.fcnt == FC_LAST) begin
      // Missing pulse at the frame boundary counts as loss
      r_next.synced = 1'b0;
      ev[IRQ_SYNC_LOST] = 1'b1;
    end

    // Serial datapath
    for (int l = 0; l < NUM_LINES; l++) begin
      if (bit_en) begin
        r_next.in_dly[l] = {r_reg.in_dly[l][SHIFT_DEP-2:0], r_reg.in_s2[l]};
        r_next.in_sr[l]  = {r_reg.in_sr[l][6:0], in_bit[l]};
        r_next.out_dly[l] = {r_reg.out_dly[l][SHIFT_DEP-2:0],
                             r_reg.out_sr[l][7]};
        r_next.oe_dly[l] = {r_reg.oe_dly[l][SHIFT_DEP-2:0],
                            ~r_reg.out_ts[l] & r_reg.mode[upper_line(l) ?
                            MODE_EN_HI : MODE_EN_LO]};
        if (byte_end) begin
          r_next.out_sr[l] = ld_byte[l];
          r_next.out_ts[l] = ld_ent[l][CM_TS_BIT];
        end else begin
          r_next.out_sr[l] = {r_reg.out_sr[l][6:0], 1'b0};
        end
      end
      r_next.sout[l] = r_reg.out_dly[l][r_reg.oshift];
      r_next.soe[l]  = r_reg.oe_dly[l][r_reg.oshift];
    end

    // Frame measurement
    if (r_reg.meas_busy && r_reg.fs_s2[r_reg.meas_idx] &&
        !r_reg.fs_d[r_reg.meas_idx]) begin
      r_next.meas      = MEAS_W'(r_reg.fcnt);
      r_next.meas_busy = 1'b0;
      ev[IRQ_MEAS]     = 1'b1;
    end

    // Special function sequencer
    case (r_reg.func)
      MTS_CMCLR: begin
        r_next.st_cnt = r_reg.st_cnt + 1'b1;
        if (st_addr == CH_LAST) begin
          r_next.func    = MTS_IDLE;
          ev[IRQ_CMCLR]  = 1'b1;
        end
      end
      MTS_BIST1: begin
        r_next.st_cnt = r_reg.st_cnt + 1'b1;
        if ((st_phase == PH_CHECK && !st_ok) || (|r_reg.ics)) begin
          r_next.bist_fail = 1'b1;
        end
        if (r_reg.st_cnt == ST_CNT_W'(ST_STEP_CYC - 1)) begin
          r_next.func   = MTS_BIST2;
          r_next.st_cnt = '0;
        end
      end
      MTS_BIST2: begin
        r_next.st_cnt = r_reg.st_cnt + 1'b1;
        if (st_phase == PH_CHECK && !st_ok) begin
          r_next.bist_fail = 1'b1;
        end
        if (r_reg.st_cnt == ST_CNT_W'(ST_STEP_CYC - 1)) begin
          r_next.func      = MTS_IDLE;
          r_next.bist_ok   = ~r_reg.bist_fail;
          r_next.bist_done = 1'b1;
          ev[IRQ_BIST]     = 1'b1;
        end
      end
      default: ;
    endcase

    // Register writes
    if (r_reg.ind_rd) begin
      r_next.ind_data = ind_rd_val;
    end
    if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_MODE:   r_next.mode   = bus_i.wdata;
        ADDR_OSHIFT: r_next.oshift = bus_i.wdata[SHIFT_W-1:0];
        ADDR_CMD: begin
          if (r_reg.func == MTS_IDLE && bus_i.wdata[CMD_CMCLR]) begin
            r_next.func   = MTS_CMCLR;
            r_next.st_cnt = '0;
          end
          bist_go = bist_go | bus_i.wdata[CMD_BIST];
          if (bus_i.wdata[CMD_MEAS] && r_reg.synced && !r_reg.meas_busy &&
              bus_i.wdata[FS_W-1:0] < FS_W'(NUM_FS)) begin
            r_next.meas_busy = 1'b1;
            r_next.meas_idx  = bus_i.wdata[FS_W-1:0];
          end
        end
        ADDR_IND_AL: r_next.ind_addr[7:0] = bus_i.wdata;
        ADDR_IND_AH: begin
          r_next.ind_addr[CH_W-1:8] = bus_i.wdata[CH_W-9:0];
          r_next.ind_sel = bus_i.wdata[IND_SEL_B:IND_SEL_DM];
          r_next.ind_rd  = bus_i.wdata[IND_READ];
        end
        ADDR_IND_DL: r_next.ind_data[7:0] = bus_i.wdata;
        ADDR_IND_DH: begin
          r_next.ind_data[CM_W-1:8] = bus_i.wdata[CM_W-9:0];
          r_next.ind_wr = 1'b1;
        end
        default: begin
          if (bus_i.addr[7:2] == ADDR_ICS0[7:2]) begin
            r_next.ics[{bus_i.addr[1:0], 3'h0} +: 8] = bus_i.wdata;
          end
        end
      endcase
    end
    if (bist_go && r_reg.func == MTS_IDLE) begin
      r_next.func      = MTS_BIST1;
      r_next.st_cnt    = '0;
      r_next.bist_fail = 1'b0;
      if (!r_reg.mode[MODE_SHIFT_SEL]) begin
        r_next.ics = '0;
      end
    end

    // Register reads, data in the following cycle
    r_next.rdata = 8'h00;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_MODE:   r_next.rdata = r_reg.mode;
        ADDR_STATUS: r_next.rdata = {3'h0, r_reg.bist_ok,
                       r_reg.func[1], r_reg.meas_busy,
                       r_reg.func == MTS_CMCLR, r_reg.synced};
        ADDR_IRQ: begin
          r_next.rdata = {3'h0, r_reg.irq_stat};
          rd_clr       = 1'b1;
        end
        ADDR_MEAS_L: r_next.rdata = r_reg.meas[7:0];
        ADDR_MEAS_H: r_next.rdata = {4'h0, r_reg.meas[MEAS_W-1:8]};
        ADDR_OSHIFT: r_next.rdata = {6'h00, r_reg.oshift};
        ADDR_IND_AL: r_next.rdata = r_reg.ind_addr[7:0];
        ADDR_IND_AH: r_next.rdata = {2'h0, r_reg.ind_sel, 1'b0,
                                     r_reg.ind_addr[CH_W-1:8]};
        ADDR_IND_DL: r_next.rdata = r_reg.ind_data[7:0];
        ADDR_IND_DH: r_next.rdata = {4'h0, r_reg.ind_data[CM_W-1:8]};
        default: begin
          if (bus_i.addr[7:2] == ADDR_ICS0[7:2]) begin
            r_next.rdata = r_reg.ics[{bus_i.addr[1:0], 3'h0} +: 8];
          end
        end
      endcase
    end

    // Events arriving with the read still stick
    r_next.irq_stat = (rd_clr ? '0 : r_reg.irq_stat) | ev;
    r_next.irq_n    = ~|r_next.irq_stat;
    r_next.irq_oe   = |r_next.irq_stat;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg       <= '0;
      r_reg.irq_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Traffic writes yield to selftest writes while it runs
  always_ff @(posedge clk_i) begin
    if (r_reg.func == MTS_BIST1) begin
      if (st_phase == PH_WRITE) begin
        dm_a[st_addr] <= st_addr[7:0] ^ DM_PAT;
        dm_b[st_addr] <= st_addr[7:0] ^ DM_PAT;
      end
    end else if (byte_end) begin
      for (int l = 0; l < NUM_LINES; l++) begin
        dm_a[{slot, LINE_W'(l)}] <= {r_reg.in_sr[l][6:0], in_bit[l]};
        dm_b[{slot, LINE_W'(l)}] <= {r_reg.in_sr[l][6:0], in_bit[l]};
      end
    end
    if (r_reg.ind_wr && r_reg.ind_sel[SEL_DM] &&
        r_reg.func == MTS_IDLE) begin
      if (r_reg.ind_sel[SEL_B]) begin
        dm_b[r_reg.ind_addr] <= r_reg.ind_data[7:0];
      end else begin
        dm_a[r_reg.ind_addr] <= r_reg.ind_data[7:0];
      end
    end
    if (r_reg.func == MTS_CMCLR ||
        (r_reg.func == MTS_BIST2 && st_phase == PH_CLEAR)) begin
      cm_a[st_addr] <= CM_CLEAR;
      cm_b[st_addr] <= CM_CLEAR;
    end else if (r_reg.func == MTS_BIST2 && st_phase == PH_WRITE) begin
      cm_a[st_addr] <= {1'b0, st_addr ^ CM_PAT};
      cm_b[st_addr] <= {1'b0, st_addr ^ CM_PAT};
    end else if (r_reg.ind_wr && !r_reg.ind_sel[SEL_DM] &&
                 r_reg.func == MTS_IDLE) begin
      if (r_reg.ind_sel[SEL_B]) begin
        cm_b[r_reg.ind_addr] <= r_reg.ind_data;
      end else begin
        cm_a[r_reg.ind_addr] <= r_reg.ind_data;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_o         = r_reg.rdata;
  assign serial_out_o    = r_reg.sout;
  assign serial_out_oe_o = r_reg.soe;
  assign irq_n_o         = r_reg.irq_n;
  assign irq_oe_o        = r_reg.irq_oe;
  assign bist_done_o     = r_reg.bist_done;
  assign bist_ok_o       = r_reg.bist_ok;

endmodule // mts_switch

// File: dv/mts_switch_assertions.sv
`timescale 1ns/100ps
// ==========================================
// Port checker
module mts_switch_assertions
  import mts_pkg::*;
#(
  parameter int ST_STEP_CYC = ST_STEP_CYC_DEF
) (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire mts_bus_s   bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic       bist_start_i,
  input wire logic       irq_n_o,
  input wire logic       irq_oe_o,
  input wire logic       bist_done_o,
  input wire logic       bist_ok_o
);
  logic        irq_rd;
  logic        st_go;
  logic [16:0] st_cnt_reg;
  assign irq_rd = bus_i.rd && bus_i.addr == ADDR_IRQ;
  assign st_go  = bist_start_i
                  || (bus_i.wr && bus_i.addr == ADDR_CMD
                      && bus_i.wdata[CMD_BIST]);
  // Saturates so a long idle spell never wraps into a false window
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) st_cnt_reg <= '0;
    else if (st_go) st_cnt_reg <= '0;
    else if (st_cnt_reg != '1) st_cnt_reg <= st_cnt_reg + 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_IRQ_OE: assert property (irq_oe_o == !irq_n_o)
    else $error("irq enable differs from line");
  AST_IRQ_REL: assert property (irq_rd |-> ##[1:2] irq_n_o)
    else $error("irq not released by status read");
  AST_IRQ_HOLD: assert property ($rose(irq_n_o) |->
    $past(irq_rd) || $past(irq_rd, 2)) else $error("irq released unread");
  AST_RDATA_IDLE: assert property (
    !$past(bus_i.rd) |-> rdata_o == 8'h00) else $error("stray read data");
  AST_DONE_PULSE: assert property (bist_done_o |=> !bist_done_o)
    else $error("selftest done not a pulse");
  AST_OK_AT_DONE: assert property ($rose(bist_ok_o) |->
    bist_done_o || $past(bist_done_o)) else $error("ok outside done");
  AST_IRQ_ON_DONE: assert property (
    bist_done_o |-> ##[0:3] !irq_n_o) else $error("no irq at selftest end");
  AST_BIST_TIME: assert property (bist_done_o |->
    st_cnt_reg + 17'h4 >= 2 * ST_STEP_CYC
    && st_cnt_reg <= 2 * ST_STEP_CYC + 2048) else $error("selftest length");
  cover property (bist_done_o && bist_ok_o);
  cover property (bist_done_o && !bist_ok_o);
  cover property (irq_rd ##1 rdata_o != 8'h00);
endmodule // mts_switch_assertions
bind mts_switch mts_switch_assertions #(.ST_STEP_CYC(ST_STEP_CYC)) chk_u (
  .clk_i, .nrst_i, .bus_i, .rdata_o, .bist_start_i, .irq_n_o, .irq_oe_o,
  .bist_done_o, .bist_ok_o);

// File: dv/mts_pcm_partner.sv
`timescale 1ns/100ps
// ==========================================
// PCM highway: sync every frame, moving data, measure edge
module mts_pcm_partner
  import mts_pkg::*;
(
  input  wire logic             clk_i,
  output logic                  sync_o,
  output logic [NUM_LINES-1:0]  data_o,
  output logic [NUM_FS-1:0]     fs_o
);
  logic [FC_W-1:0] cnt_reg;
  initial begin
    cnt_reg = '0;
    sync_o = 1'b0;
    data_o = '0;
    fs_o = '0;
  end
  always @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 1'b1;
    sync_o <= cnt_reg == FC_LAST;
    data_o <= NUM_LINES'({2{cnt_reg[FC_W-1:2], cnt_reg[4:0]}});
    fs_o <= {NUM_FS{cnt_reg >= 11'h100 && cnt_reg < 11'h500}};
  end
endmodule // mts_pcm_partner

// File: dv/testbench.sv
`timescale 1ns/100ps
// ==========================================
// Testbench
module testbench
  import mts_pkg::*;
;
  localparam int ST = 6144;
  logic                 clk_i = 1'b0;
  logic                 nrst_i = 1'b0;
  mts_bus_s             bus_i = '0;
  logic                 bist_start_i = 1'b0;
  logic                 sync;
  logic [NUM_LINES-1:0] din, so, oe;
  logic [NUM_FS-1:0]    fs;
  logic [7:0]           rdata_o, d, h;
  logic                 irq_n_o, irq_oe_o, bist_done_o, bist_ok_o;
  int                   n_mismatch = 0, n_tests = 0, c0, c1, c2;
  initial forever #25 clk_i = ~clk_i;
  mts_switch #(.ST_STEP_CYC(ST)) dut_u (.clk_i, .nrst_i, .bus_i, .rdata_o,
    .frame_sync_pulse_i(sync), .serial_in_i(din), .frame_measure_in_i(fs),
    .bist_start_i, .serial_out_o(so), .serial_out_oe_o(oe), .irq_n_o,
    .irq_oe_o, .bist_done_o, .bist_ok_o);
  mts_pcm_partner pcm_u (.clk_i, .sync_o(sync), .data_o(din), .fs_o(fs));
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_i) bus_i <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_i) bus_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i) bus_i <= '0;
    #1 d = rdata_o;
  endtask
  task automatic wait_irq(input logic [7:0] bits);
    for (int i = 0; i < 8000 && irq_n_o !== 1'b0; i++) @(posedge clk_i);
    rd(ADDR_IRQ);
    chk(d & bits, bits);
  endtask
  task automatic count_oe();
    c0 = 0;
    c1 = 0;
    c2 = 0;
    repeat (2048) begin
      @(posedge clk_i);
      c0 += int'(oe[0] === 1'b1);
      c1 += int'(oe[16] === 1'b1);
      c2 += int'(oe[15:1] !== '0 || oe[31:17] !== '0);
      // Lines 0 and 16 read the same address of twin memories
      c2 += int'(oe[0] === 1'b1 && so[0] !== so[16]);
    end
  endtask
  task automatic bist_wait(input logic ok);
    int n;
    n = 0;
    while (n < 3 * ST && bist_done_o !== 1'b1) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(n >= 2 * ST - 8 && n < 3 * ST, 1'b1);
    @(posedge clk_i);
    #1 chk(bist_ok_o, ok);
    wait_irq(8'h10);
  endtask
  task automatic t_reset();
    chk(oe, '0);
    chk(irq_n_o, 1'b1);
    rd(ADDR_MODE);
    chk(d, 8'h00);
    rd(8'hFF);
    chk(d, 8'h00);
  endtask
  task automatic t_sync();
    repeat (3 * 2048) @(posedge clk_i);
    rd(ADDR_STATUS);
    chk(d[0], 1'b1);
    wait_irq(8'h02);
    repeat (2) @(posedge clk_i);
    #1 chk(irq_n_o, 1'b1);
  endtask
  task automatic t_route();
    wr(ADDR_CMD, 8'h10);
    wait_irq(8'h04);
    wr(ADDR_MODE, 8'h0C);
    count_oe();
    chk(c0 + c1 + c2, 0);
    // Slot 5 of line 0 via memory a, of line 16 via memory b
    foreach (h[i]) if (i < 2) begin
      wr(ADDR_IND_AL, i ? 8'hB0 : 8'hA0);
      wr(ADDR_IND_AH, i ? 8'h20 : 8'h00);
      wr(ADDR_IND_DL, 8'h00);
      wr(ADDR_IND_DH, 8'h00);
    end
    repeat (64) @(posedge clk_i);
    count_oe();
    chk(c0, 32'd32);
    chk(c1, 32'd32);
    chk(c2, 32'd0);
    wr(ADDR_MODE, 8'h08);
    // Let the enable pipeline drain the old mode
    repeat (8) @(posedge clk_i);
    count_oe();
    chk(c0, 32'd0);
    chk(c1, 32'd32);
  endtask
  task automatic t_meas();
    wr(ADDR_CMD, 8'h0A);
    wait_irq(8'h08);
    rd(ADDR_MEAS_H);
    h = d;
    rd(ADDR_MEAS_L);
    chk(h[7:3], 5'h00);
    chk({h[2:0], d} inside {[11'h0F0 : 11'h110]}, 1'b1);
  endtask
  task automatic t_bist();
    wr(ADDR_ICS0, 8'hFF);
    wr(ADDR_MODE, 8'h0C);
    @(posedge clk_i) bist_start_i <= 1'b1;
    @(posedge clk_i) bist_start_i <= 1'b0;
    bist_wait(1'b1);
    rd(ADDR_ICS0);
    chk(d, 8'h00);
    count_oe();
    chk(c0 + c1 + c2, 0);
    wr(ADDR_MODE, 8'h0D);
    wr(ADDR_ICS0, 8'h04);
    wr(ADDR_CMD, 8'h20);
    bist_wait(1'b0);
    rd(ADDR_STATUS);
    chk(d[4], 1'b0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_sync();
    t_route();
    t_meas();
    t_bist();
    give_verdict();
  end
  // Tests need about 41000 cycles; leave margin
  initial begin
    repeat (70000) @(posedge clk_i);
    n_mismatch++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule // testbench
